// ==== nvm_seq_map.vh ====
// register map, field positions, codes and timing for the data eeprom sequencer
`ifndef NVM_SEQ_MAP_VH
`define NVM_SEQ_MAP_VH
// Notes on behaviour
// RQ1: start only after keys 0x55 then 0xaa
// RQ2: wrong key or other access resets tracker
// RQ3: software puts two nops after start
// RQ4: 4K words at 0x7ff000 to 0x7ffffe
// RQ5: erase or program one word or block
// RQ6: target from high and low address registers; the code takes the target from addrLowQ[11:0] only
// RQ7: low-word table read and write access array
// RQ8: operations never stall the processor
// RQ9: no new op while busy; reads undefined
// RQ10: operation lasts nominally 2 ms
// RQ11: software erases before programming
// RQ12: start bit set-only; hardware clears it
// RQ13: start blocked unless gate bit set
// RQ14: gate and start in one write: ignored
// RQ15: gate cleared at power-up only
// RQ16: clearing gate never aborts running operation
// RQ17: pin or watchdog reset sets abort flag
// RQ18: completion clears start, sets sticky flag
// RQ19: control 0x4045 selects block erase
// RQ20: control 0x4044 selects word erase
// RQ21: software disables interrupts around key sequence
// RQ22: control and key reset to zero
// RQ23: start bit is control bit 15
// RQ24: key register is write-only
// RQ25: high address captures table address 23:16

////////////////////////////////////////////////////////////////////////////////
// register indices; byte address is index times four
`define IDX_CONTROL      14'h0762
`define IDX_ADDR_LOW     14'h0764
`define IDX_UNLOCK_KEY   14'h0766
`define IDX_ADDR_HIGH    14'h0768
`define IDX_STATUS       14'h076a
// control fields
`define CTL_START        15
`define CTL_GATE         14
`define CTL_ERR          13
`define CTL_OP_MSB       6
`define CTL_ERASE        6
`define CTL_RESET        16'h0000
`define KEY_RESET        16'h0000
// operation select codes
`define OP_BLK_ERASE     7'h45
`define OP_WRD_ERASE     7'h44
`define OP_WRD_PROG      7'h04
`define OP_BLK_PROG      7'h0a
// unlock keys
`define KEY_FIRST        16'h0055
`define KEY_SECOND       16'h00aa
// eeprom window and contents
`define EE_PAGE          12'h7ff
`define EE_ERASED        16'hffff
`define BLK_LAST         4'hf
// status fields
`define STS_DONE         0
// timing
`define OP_TIME_US       2000
`define CLK_MHZ          20
`endif

// ==== ee_word_mem.v ====
// data eeprom array, one write port and one registered read port
`timescale 1ns/10ps
`default_nettype none
module ee_word_mem (
  // clock
  input  wire        clk,
  // write port
  input  wire        we,
  input  wire [11:0] wAddr,
  input  wire [15:0] wData,
  // read port
  input  wire        re,
  input  wire [11:0] rAddr,
  output reg  [15:0] rData
);
  reg [15:0] cells [0:4095];

  always @(posedge clk) begin
    if (we) begin
      cells[wAddr] <= wData;
    end
    if (re) begin
      rData <= cells[rAddr];
    end
  end
endmodule // ee_word_mem
`default_nettype wire

// ==== nvm_op_timer.v ====
// operation duration counter, one-cycle done pulse
`timescale 1ns/10ps
`default_nettype none
module nvm_op_timer #(
  parameter [15:0] CYCLES = 16'd40000
) (
  // clock and reset
  input  wire clk,
  input  wire sys_rst,
  // control
  input  wire start,
  input  wire abort,
  output reg  done
);
  reg [15:0] countQ;
  reg        runQ;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      countQ <= 16'h0000;
      runQ   <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        runQ <= 1'b0;
      end else if (start) begin
        countQ <= CYCLES - 16'h0001;
        runQ   <= 1'b1;
      end else if (runQ) begin
        if (countQ == 16'h0000) begin
          runQ <= 1'b0;
          done <= 1'b1; // [RQ10]
        end else begin
          countQ <= countQ - 16'h0001;
        end
      end
    end
  end
endmodule // nvm_op_timer
`default_nettype wire

// ==== data_eeprom_nvm_sequencer.v ====
// data eeprom erase/program sequencer with avalon register slave
//
// Chosen here: the Avalon-MM interface to the registers.
`include "nvm_seq_map.vh"
`timescale 1ns/10ps
`default_nettype none
module data_eeprom_nvm_sequencer #(
  parameter [15:0] OP_CYCLES = `OP_TIME_US * `CLK_MHZ
) (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // avalon-mm register slave
  input  wire [15:0] avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWriteData,
  input  wire [3:0]  avsByteEnable,
  output reg  [31:0] avsReadData,
  output wire        avsWaitRequest,
  // cpu table access port
  input  wire        tblRead,
  input  wire        tblWrite,
  input  wire [23:0] tblAddr,
  input  wire [15:0] tblWriteData,
  output wire [15:0] tblReadData,
  output reg         tblReadValid,
  // warm reset events, one-cycle pulses
  input  wire        extResetPin,
  input  wire        watchdogTimeout,
  // status
  output wire        opCompleteIrqFlag,
  output wire        busy
);

  ////////////////////////////////////////////////////////////////////////////////
  // states
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_WAIT = 4'b0010;
  localparam [3:0] ST_EXEC = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;
  localparam [2:0] K_IDLE  = 3'b001;
  localparam [2:0] K_HALF  = 3'b010;
  localparam [2:0] K_ARMED = 3'b100;

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  reg         ackQ;
  reg  [3:0]  stateQ;
  reg  [2:0]  trkQ;
  reg         startQ;
  reg         gateQ;
  reg         errQ;
  reg  [6:0]  opSelQ;
  reg  [6:0]  runOpQ;
  reg         doneFlagQ;
  reg  [15:0] addrLowQ;
  reg  [7:0]  addrHighQ;
  reg  [11:0] targetQ;
  reg  [3:0]  stepQ;
  reg  [15:0] latchQ [0:15];
  reg  [31:0] rdMux;
  reg         opValid;
  reg  [6:0]  newOpSel;
  wire        acc;
  wire        wrAcc;
  wire        rdAcc;
  wire        addrAligned;
  wire        selCtl;
  wire        selLow;
  wire        selKey;
  wire        selHigh;
  wire        selSts;
  wire [15:0] wData;
  wire        warmRst;
  wire        tblAny;
  wire        tblInEe;
  wire        startOk;
  wire        timerDone;
  wire        isBlock;
  wire        isErase;
  wire        memWe;
  wire [11:0] memWAddr;
  wire [15:0] memWData;
  wire [15:0] latchSel;

  ////////////////////////////////////////////////////////////////////////////////
  // avalon handshake: request seen, answered one cycle later
  assign avsWaitRequest = (avsRead | avsWrite) & ~ackQ;
  assign acc            = ackQ;
  assign wrAcc          = acc & avsWrite;
  assign rdAcc          = acc & avsRead;
  assign addrAligned    = (avsAddress[1:0] == 2'b00);
  assign selCtl         = addrAligned & (avsAddress[15:2] == `IDX_CONTROL);
  assign selLow         = addrAligned & (avsAddress[15:2] == `IDX_ADDR_LOW);
  assign selKey         = addrAligned & (avsAddress[15:2] == `IDX_UNLOCK_KEY);
  assign selHigh        = addrAligned & (avsAddress[15:2] == `IDX_ADDR_HIGH);
  assign selSts         = addrAligned & (avsAddress[15:2] == `IDX_STATUS);
  assign wData          = avsWriteData[15:0];
  assign warmRst        = extResetPin | watchdogTimeout;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= (avsRead | avsWrite) & ~ackQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data, registered in the request cycle
  always @* begin
    rdMux = 32'h00000000;
    if (selCtl) begin
      rdMux[15:0] = {startQ, gateQ, errQ, 6'h00, opSelQ};
    end else if (selLow) begin
      rdMux[15:0] = addrLowQ;
    end else if (selHigh) begin
      rdMux[15:0] = {8'h00, addrHighQ};
    end else if (selSts) begin
      rdMux[`STS_DONE] = doneFlagQ;
    end
    // key register is write-only and reads zero [RQ24]
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avsReadData <= 32'h00000000;
    end else if (avsRead & ~ackQ) begin
      avsReadData <= rdMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // start decision
  always @* begin
    newOpSel = avsByteEnable[0] ? wData[`CTL_OP_MSB:0] : opSelQ;
    case (newOpSel)
      `OP_BLK_ERASE: opValid = 1'b1; // [RQ19] [RQ5]
      `OP_WRD_ERASE: opValid = 1'b1; // [RQ20]
      `OP_WRD_PROG:  opValid = 1'b1;
      `OP_BLK_PROG:  opValid = 1'b1;
      default:       opValid = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // start qualification
  // gate must already be set before this write [RQ13] [RQ14]
  // keys must immediately precede [RQ1]; busy refuses [RQ9]
  assign startOk = wrAcc & selCtl & avsByteEnable[1] & wData[`CTL_START] &
                   (trkQ == K_ARMED) & gateQ & (stateQ == ST_IDLE) & opValid & ~warmRst;

  ////////////////////////////////////////////////////////////////////////////////
  // unlock tracker
  assign tblAny = tblRead | tblWrite;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trkQ <= K_IDLE;
    end else if (warmRst) begin
      trkQ <= K_IDLE;
    end else if (wrAcc & selKey & (avsByteEnable[1:0] == 2'b11)) begin
      if (wData == `KEY_FIRST) begin
        trkQ <= K_HALF; // [RQ1]
      end else if ((trkQ == K_HALF) && (wData == `KEY_SECOND)) begin
        trkQ <= K_ARMED; // [RQ1]
      end else begin
        trkQ <= K_IDLE; // [RQ2]
      end
    end else if (wrAcc | rdAcc | tblAny) begin
      trkQ <= K_IDLE; // [RQ2]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control register
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gateQ  <= 1'b0; // [RQ15] [RQ22]
      opSelQ <= 7'h00;
      errQ   <= 1'b0;
    end else begin
      if (wrAcc & selCtl & avsByteEnable[1]) begin
        gateQ <= wData[`CTL_GATE]; // [RQ16]
        errQ  <= wData[`CTL_ERR];
      end
      if (wrAcc & selCtl & avsByteEnable[0]) begin
        opSelQ <= wData[`CTL_OP_MSB:0];
      end
      if (warmRst) begin
        opSelQ <= 7'h00;
        if (stateQ != ST_IDLE) begin
          errQ <= 1'b1; // [RQ17]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // completion flag, set wins over clear
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      doneFlagQ <= 1'b0;
    end else if (stateQ == ST_DONE) begin
      doneFlagQ <= 1'b1; // [RQ18]
    end else if (wrAcc & selSts & avsByteEnable[0] & ~wData[`STS_DONE]) begin
      doneFlagQ <= 1'b0;
    end
  end

  assign opCompleteIrqFlag = doneFlagQ;

  ////////////////////////////////////////////////////////////////////////////////
  // address registers and write latches, no reset
  assign tblInEe = (tblAddr[23:12] == `EE_PAGE); // [RQ4]

  always @(posedge clk) begin
    if (tblAny) begin
      addrLowQ  <= tblAddr[15:0]; // [RQ6]
      addrHighQ <= tblAddr[23:16]; // [RQ25]
    end else begin
      if (wrAcc & selLow & avsByteEnable[0]) begin
        addrLowQ[7:0] <= wData[7:0];
      end
      if (wrAcc & selLow & avsByteEnable[1]) begin
        addrLowQ[15:8] <= wData[15:8];
      end
      if (wrAcc & selHigh & avsByteEnable[0]) begin
        addrHighQ <= wData[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write latches, one per block entry, loaded by low-word table writes
  assign latchSel = 16'h0001 << tblAddr[3:0];

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_latch
      always @(posedge clk) begin
        if (tblWrite & tblInEe & latchSel[gi]) begin
          latchQ[gi] <= tblWriteData; // [RQ7]
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer; cpu keeps running throughout [RQ8]
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ  <= ST_IDLE;
      startQ  <= 1'b0; // [RQ22]
      runOpQ  <= 7'h00;
      targetQ <= 12'h000;
      stepQ   <= 4'h0;
    end else if (warmRst) begin
      stateQ <= ST_IDLE;
      startQ <= 1'b0; // [RQ17]
    end else begin
      case (stateQ)
        ST_IDLE: begin
          if (startOk) begin
            startQ  <= 1'b1; // [RQ12] [RQ23]
            runOpQ  <= newOpSel;
            targetQ <= addrLowQ[11:0]; // [RQ6]
            stepQ   <= 4'h0;
            stateQ  <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (timerDone) begin
            stateQ <= ST_EXEC; // [RQ10]
          end
        end
        ST_EXEC: begin
          if (~isBlock | (stepQ == `BLK_LAST)) begin
            stateQ <= ST_DONE;
          end
          stepQ <= stepQ + 4'h1;
        end
        ST_DONE: begin
          startQ <= 1'b0; // [RQ12] [RQ18]
          stateQ <= ST_IDLE;
        end
        default: begin
          stateQ <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status outputs
  assign busy    = startQ;

  // running operation decode
  assign isBlock = (runOpQ == `OP_BLK_ERASE) | (runOpQ == `OP_BLK_PROG); // [RQ5]
  assign isErase = runOpQ[`CTL_ERASE];

  ////////////////////////////////////////////////////////////////////////////////
  // array update
  assign memWe    = (stateQ == ST_EXEC);
  assign memWAddr = isBlock ? {targetQ[11:4], stepQ} : targetQ; // [RQ5]
  assign memWData = isErase ? `EE_ERASED :
                    (isBlock ? latchQ[stepQ] : latchQ[targetQ[3:0]]);

  ////////////////////////////////////////////////////////////////////////////////
  // operation timer
  nvm_op_timer #(
    .CYCLES (OP_CYCLES)
  ) u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (startOk),
    .abort   (warmRst),
    .done    (timerDone)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // reads during an operation may return stale data [RQ9] [RQ7]
  ee_word_mem u_mem (
    .clk   (clk),
    .we    (memWe),
    .wAddr (memWAddr),
    .wData (memWData),
    .re    (tblRead),
    .rAddr (tblAddr[11:0]),
    .rData (tblReadData)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // table read strobe, valid the cycle after the request
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tblReadValid <= 1'b0;
    end else begin
      tblReadValid <= tblRead;
    end
  end

endmodule // data_eeprom_nvm_sequencer
`default_nettype wire

// ==== nvm_seq_assertions.sv ====
// assertion checker for the data eeprom sequencer
`timescale 1ns/10ps
`default_nettype none
module nvm_seq_checker #(
  parameter [15:0] OP_CYCLES = 16'd40000
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // register bus
  input wire logic [15:0] avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [31:0] avsReadData,
  input wire logic        avsWaitRequest,
  // table port, events, status
  input wire logic        tblRead,
  input wire logic        tblReadValid,
  input wire logic        extResetPin,
  input wire logic        watchdogTimeout,
  input wire logic        opCompleteIrqFlag,
  input wire logic        busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [16:0] busyCnt_q;
  wire  [16:0] busyCnt_d = busy ? busyCnt_q + 17'd1 : 17'd0;
  wire         startWr = avsWrite && !avsWaitRequest && avsAddress == 16'h1d88 && avsWriteData[15];
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) busyCnt_q <= 17'd0;
    else busyCnt_q <= busyCnt_d;
  end
  a_wait_one: assert property ($rose(avsRead | avsWrite) |-> avsWaitRequest ##1 !avsWaitRequest)
    else $error("waitrequest not one cycle");
  a_idle_nowait: assert property (!(avsRead | avsWrite) |-> !avsWaitRequest)
    else $error("waitrequest without request");
  a_start_cause: assert property ($rose(busy) |-> $past(startWr) || $past(startWr, 2))
    else $error("busy rose without start write");
  a_done_flag: assert property ($fell(busy) && !$past(extResetPin) && !$past(watchdogTimeout)
    |-> opCompleteIrqFlag && busyCnt_q >= OP_CYCLES)
    else $error("completion early or flag missing");
  a_op_max: assert property (busy |-> busyCnt_q <= OP_CYCLES + 17'd18)
    else $error("operation too long");
  a_flag_hold: assert property (opCompleteIrqFlag && !avsWrite |=> opCompleteIrqFlag)
    else $error("flag dropped by hardware");
  a_abort_stop: assert property (busy && (extResetPin || watchdogTimeout) |=> !busy && $stable(opCompleteIrqFlag))
    else $error("warm reset did not abort");
  a_rdv_pulse: assert property (tblReadValid == $past(tblRead))
    else $error("table read valid misplaced");
  a_key_hidden: assert property (avsRead && !avsWaitRequest && avsAddress == 16'h1d98 |-> avsReadData == 32'h0)
    else $error("key readable");
endmodule // nvm_seq_checker
bind data_eeprom_nvm_sequencer nvm_seq_checker #(.OP_CYCLES(OP_CYCLES)) chk (.clk(clk), .sys_rst(sys_rst),
  .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
  .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .tblRead(tblRead), .tblReadValid(tblReadValid),
  .extResetPin(extResetPin), .watchdogTimeout(watchdogTimeout), .opCompleteIrqFlag(opCompleteIrqFlag), .busy(busy));
`default_nettype wire

// ==== cpu_table_model.sv ====
// cpu model: table reads and writes, warm reset events
`timescale 1ns/10ps
`default_nettype none
module cpu_table_model (
  // clock
  input  wire logic        clk,
  // table port
  output var  logic        tblRead,
  output var  logic        tblWrite,
  output var  logic [23:0] tblAddr,
  output var  logic [15:0] tblWriteData,
  input  wire logic [15:0] tblReadData,
  input  wire logic        tblReadValid,
  // warm reset events
  output var  logic        extResetPin,
  output var  logic        watchdogTimeout
);
  initial begin
    {tblRead, tblWrite, extResetPin, watchdogTimeout} = 4'h0;
    tblAddr = 24'h0;
    tblWriteData = 16'h0;
  end
  // low-word table write loads a latch
  task automatic tblWr(input logic [23:0] a, input logic [15:0] d);
    @(posedge clk);
    tblWrite <= 1'b1;
    tblAddr <= a;
    tblWriteData <= d;
    @(posedge clk);
    tblWrite <= 1'b0;
    tblAddr <= ~a;
    tblWriteData <= ~d;
  endtask
  // low-word table read, data with valid one cycle later
  task automatic tblRd(input logic [23:0] a, output logic [15:0] d);
    @(posedge clk);
    tblRead <= 1'b1;
    tblAddr <= a;
    @(posedge clk);
    tblRead <= 1'b0;
    tblAddr <= ~a;
    @(negedge clk);
    d = tblReadValid ? tblReadData : 16'hxxxx;
  endtask
  // one-cycle pin reset (0) or watchdog reset (1)
  task automatic warm(input logic sel);
    @(posedge clk);
    extResetPin <= !sel;
    watchdogTimeout <= sel;
    @(posedge clk);
    extResetPin <= 1'b0;
    watchdogTimeout <= 1'b0;
  endtask
endmodule // cpu_table_model
`default_nettype wire

// ==== tb_top.sv ====
// self-checking testbench for the data eeprom sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin failures++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic        clk, sys_rst, avsRead, avsWrite;
  logic [15:0] avsAddress, r;
  logic [31:0] avsWriteData;
  logic [3:0]  avsByteEnable;
  wire  [31:0] avsReadData;
  wire  [23:0] tblAddr;
  wire  [15:0] tblWriteData, tblReadData;
  wire         avsWaitRequest, tblRead, tblWrite, tblReadValid, extResetPin, watchdogTimeout, flag, busy;
  int          failures, nTests;
  localparam [15:0] CTL = 16'h1d88, ADL = 16'h1d90, KEY = 16'h1d98, ADH = 16'h1da0, STS = 16'h1da8;
  data_eeprom_nvm_sequencer #(.OP_CYCLES(16'd20)) dut (.clk(clk), .sys_rst(sys_rst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .tblRead(tblRead), .tblWrite(tblWrite),
    .tblAddr(tblAddr), .tblWriteData(tblWriteData), .tblReadData(tblReadData), .tblReadValid(tblReadValid),
    .extResetPin(extResetPin), .watchdogTimeout(watchdogTimeout), .opCompleteIrqFlag(flag), .busy(busy));
  cpu_table_model cpu (.clk(clk), .tblRead(tblRead), .tblWrite(tblWrite), .tblAddr(tblAddr),
    .tblWriteData(tblWriteData), .tblReadData(tblReadData), .tblReadValid(tblReadValid),
    .extResetPin(extResetPin), .watchdogTimeout(watchdogTimeout));
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    avsAddress <= a;
    avsWriteData <= {16'h0, d};
    avsByteEnable <= 4'h3;
    avsWrite <= 1'b1;
    do @(posedge clk); while (avsWaitRequest !== 1'b0);
    avsWrite <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    avsAddress <= a;
    avsRead <= 1'b1;
    do @(posedge clk); while (avsWaitRequest !== 1'b0);
    r = avsReadData[15:0];
    avsRead <= 1'b0;
  endtask
  // keys, optional stray access, control write, then two idle cycles
  task automatic seq(input logic [15:0] k1, k2, input logic mid, input logic [15:0] c);
    wr(KEY, k1);
    if (mid) rd(CTL);
    wr(KEY, k2);
    wr(CTL, c);
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic go(input logic [15:0] c);
    seq(16'h0055, 16'h00aa, 1'b0, c | 16'h8000);
    `CHK(busy, 1'b1)
  endtask
  task automatic waitIdle;
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk);
    `CHK(busy, 1'b0)
    `CHK(flag, 1'b1)
    wr(STS, 16'h0);
    @(negedge clk);
    `CHK(flag, 1'b0)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic tReset;
    rd(CTL);
    `CHK(r, 16'h0)
    rd(KEY);
    `CHK(r, 16'h0)
  endtask
  task automatic tWord;
    cpu.tblWr(24'h7ff010, 16'h1234);
    wr(CTL, 16'h4044);
    go(16'h4044);
    rd(CTL);
    `CHK(r[15], 1'b1)
    wr(CTL, 16'h4044);
    @(negedge clk);
    `CHK(busy, 1'b1)
    waitIdle;
    rd(CTL);
    `CHK(r[15:14], 2'b01)
    go(16'h4004);
    wr(CTL, 16'h0004);
    waitIdle;
    cpu.tblRd(24'h7ff010, r);
    `CHK(r, 16'h1234)
  endtask
  task automatic tBlock;
    cpu.tblWr(24'h7ff01c, 16'h5a5a);
    wr(CTL, 16'h4045);
    go(16'h4045);
    waitIdle;
    cpu.tblRd(24'h7ff010, r);
    `CHK(r, 16'hffff)
    cpu.tblRd(24'h7ff01f, r);
    `CHK(r, 16'hffff)
  endtask
  task automatic tRefuse;
    wr(CTL, 16'h0044);
    seq(16'h0055, 16'h00aa, 1'b0, 16'hc044);
    `CHK(busy, 1'b0)
    seq(16'h00aa, 16'h0055, 1'b0, 16'hc044);
    `CHK(busy, 1'b0)
    seq(16'h0055, 16'h00aa, 1'b1, 16'hc044);
    `CHK(busy, 1'b0)
    seq(16'h0055, 16'h0055, 1'b0, 16'hc044);
    `CHK(busy, 1'b0)
    wr(CTL, 16'h0044);
    seq(16'h0055, 16'h00aa, 1'b0, 16'h8044);
    `CHK(busy, 1'b0)
  endtask
  task automatic tAbort;
    for (int s = 0; s < 2; s++) begin
      cpu.tblWr(24'h7ff020, 16'h0f0f);
      wr(CTL, 16'h4004);
      go(16'h4004);
      cpu.warm(s[0]);
      @(negedge clk);
      `CHK(busy, 1'b0)
      `CHK(flag, 1'b0)
      rd(CTL);
      `CHK(r[14:13], 2'b11)
      rd(ADL);
      `CHK(r, 16'hf020)
      rd(ADH);
      `CHK(r[7:0], 8'h7f)
    end
  endtask
  task report_and_stop;
    $display("failures=%0d comparisons=%0d", failures, nTests);
    if (failures == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop;
  end
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {avsRead, avsWrite} = 2'b00;
    avsAddress = 16'h0;
    avsWriteData = 32'h0;
    avsByteEnable = 4'h0;
    failures = 0;
    nTests = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    tReset;
    tWord;
    tBlock;
    tRefuse;
    tAbort;
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
